// ---- core/suspend_powerdown_cmd_gate.sv ----
// Instruction acceptance gate: suspend filtering, power-down entry and release.
// Assumes link pins from the host are asynchronous; the status inputs share clk.
`timescale 1ns/1ps
module suspend_powerdown_cmd_gate
	import cmd_gate_pkg::*;
#(
	parameter int ENTRY_CYCLES   = entry_cycles,
	parameter int RELEASE_CYCLES = release_cycles
)(
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire link_pins_t            pins,
	input  wire logic                  write_in_progress_flag,
	input  wire logic                  program_active,
	input  wire logic                  erase_active,
	output cmd_out_t                   accepted,
	output logic                       refused,
	output logic                       soft_reset,
	output logic                       power_down_flag,
	output logic                       release_busy,
	output logic                       four_wire_command_mode,
	output logic                       program_suspended_flag,
	output logic                       erase_suspended_flag,
	output logic [func_reg_w-1:0]      suspend_field
);

	typedef struct packed {
		gate_mode_t             mode;
		logic                   four_wire;
		logic                   prog_sus;
		logic                   erase_sus;
		logic                   reset_armed;
		logic [7:0]             shift;
		logic [2:0]             bit_cnt;
		logic                   got_byte;
		logic [7:0]             opcode;
		logic [delay_cnt_w-1:0] delay_cnt;
		cmd_out_t               acc;
		logic                   rej;
		logic                   srst_pulse;
	} gate_state_t;

	gate_state_t st_reg;
	gate_state_t st_next;

	logic [1:0] ctl_level;
	logic [1:0] ctl_rise;
	logic [1:0] ctl_fall;
	logic [3:0] sio_level;
	logic       commit;
	logic       allowed;

	// Chip enable and clock pins, then data pins; matching delays keep them aligned
	edge_sync #(.W(2), .RST_VAL(2'h2)) ctl_sync ( // Idle: chip enable high, clock low
		.clk      (clk),
		.srst     (srst),
		.ce       (ce),
		.async_in ({pins.chip_en_n, pins.sclk}),
		.level    (ctl_level),
		.rise     (ctl_rise),
		.fall     (ctl_fall)
	);

	edge_sync #(.W(4)) sio_sync (
		.clk      (clk),
		.srst     (srst),
		.ce       (ce),
		.async_in (pins.sio),
		.level    (sio_level),
		.rise     (),
		.fall     ()
	);

	// Suspend permission table; erase_ok only when an erase alone is suspended
	function automatic logic suspend_allows(input logic [7:0] op, input logic erase_ok);
		case (op)
			normal_read_cmd, fast_read_cmd, dual_io_fast_read_cmd, dual_out_fast_read_cmd,
			quad_io_fast_read_cmd, quad_out_fast_read_cmd, double_rate_read_cmd,
			dual_double_rate_read_cmd, quad_double_rate_read_cmd:
				return 1'b1;
			status_read_cmd, function_reg_read_cmd, error_flags_clear_cmd:
				return 1'b1;
			volatile_read_param_set_cmd, volatile_read_param_alt_cmd,
			volatile_ext_param_set_cmd, read_param_read_cmd, ext_param_read_cmd:
				return 1'b1;
			standard_id_read_cmd, quad_standard_id_read_cmd, unique_number_read_cmd,
			param_table_read_cmd, info_row_read_cmd, boot_reg_read_cmd,
			legacy_id_read_cmd:
				return 1'b1;
			maker_device_id_read_cmd:
				return 1'b1;
			no_operation_cmd, reset_arm_cmd, soft_reset_cmd, resume_cmd, resume_alt_cmd:
				return 1'b1;
			serial_page_program_cmd, quad_page_program_cmd, quad_page_program_alt_cmd,
			write_latch_set_cmd, suspend_cmd, suspend_alt_cmd, sector_unlock_cmd,
			sector_lock_cmd:
				return erase_ok;
			default:
				return 1'b0;
		endcase
	endfunction : suspend_allows

	// Permitted set follows the gate mode and suspend flags
	always_comb
	begin
		allowed = 1'b0;
		unique case (st_reg.mode)
			mode_active:
			begin
				if (st_reg.prog_sus || st_reg.erase_sus)
					allowed = suspend_allows(st_reg.opcode,
						st_reg.erase_sus && !st_reg.prog_sus);
				else
					allowed = 1'b1;
				if (st_reg.opcode == soft_reset_cmd && !st_reg.reset_armed)
					allowed = 1'b0;
			end
			mode_entering, mode_powered_down:
				allowed = (st_reg.opcode == power_down_release_cmd)
					&& !write_in_progress_flag;
			mode_releasing:
				allowed = 1'b0;
		endcase
	end

	// Shifter, commit decode, delay counters
	always_comb
	begin
		st_next            = st_reg;
		st_next.acc.valid  = 1'b0;
		st_next.rej        = 1'b0;
		st_next.srst_pulse = 1'b0;
		commit             = 1'b0;
		if (ce)
		begin
			// Opcode capture; four-wire mode takes a nibble per edge
			if (ctl_fall[1])
			begin
				st_next.bit_cnt  = '0;
				st_next.got_byte = 1'b0;
			end
			else if (!ctl_level[1] && ctl_rise[0])
			begin
				if (st_reg.four_wire)
				begin
					st_next.shift   = {st_reg.shift[3:0], sio_level};
					st_next.bit_cnt = st_reg.bit_cnt + four_wire_step;
				end
				else
				begin
					st_next.shift   = {st_reg.shift[6:0], sio_level[0]};
					st_next.bit_cnt = st_reg.bit_cnt + single_wire_step;
				end
				if (st_next.bit_cnt == 3'h0 && !st_reg.got_byte)
				begin
					st_next.got_byte = 1'b1;
					st_next.opcode   = st_next.shift;
				end
			end
			// Entry and release timers
			if (st_reg.mode == mode_entering || st_reg.mode == mode_releasing)
			begin
				if (st_reg.delay_cnt == '0)
					st_next.mode = (st_reg.mode == mode_entering) ? mode_powered_down
						: mode_active;
				else
					st_next.delay_cnt = st_reg.delay_cnt - 1'b1;
			end
			// Partial bytes never commit and leave state alone
			commit = ctl_rise[1] && st_reg.got_byte && (st_reg.bit_cnt == 3'h0);
			if (commit)
			begin
				st_next.acc.opcode = st_reg.opcode;
				st_next.acc.valid  = allowed;
				st_next.rej        = !allowed;
			end
			if (commit && allowed)
			begin
				st_next.reset_armed = (st_reg.opcode == reset_arm_cmd);
				if (st_reg.mode != mode_active)
				begin
					st_next.mode      = mode_releasing;
					st_next.delay_cnt = delay_cnt_w'(RELEASE_CYCLES - 1);
				end
				else
				begin
					case (st_reg.opcode)
						power_down_enter_cmd:
						begin
							st_next.mode      = mode_entering;
							st_next.delay_cnt = delay_cnt_w'(ENTRY_CYCLES - 1);
						end
						four_wire_mode_enter_cmd:
							st_next.four_wire = 1'b1;
						four_wire_mode_exit_cmd:
							st_next.four_wire = 1'b0;
						suspend_cmd, suspend_alt_cmd:
						begin
							// Program nested in an erase suspend suspends as a program
							if (program_active)
								st_next.prog_sus = 1'b1;
							else if (erase_active)
								st_next.erase_sus = 1'b1;
						end
						resume_cmd, resume_alt_cmd:
						begin
							if (st_reg.prog_sus)
								st_next.prog_sus = 1'b0;
							else
								st_next.erase_sus = 1'b0;
						end
						soft_reset_cmd:
							st_next.srst_pulse = 1'b1;
						default:
							st_next.reset_armed = st_next.reset_armed;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_reg <= '{mode: mode_active, default: '0};
		else if (ce)
			st_reg <= st_next; // Low ce freezes the pulses as well
	end

	// Outputs straight from state
	assign accepted               = st_reg.acc;
	assign refused                = st_reg.rej;
	assign soft_reset             = st_reg.srst_pulse;
	assign power_down_flag        = (st_reg.mode == mode_powered_down);
	assign release_busy           = (st_reg.mode == mode_releasing);
	assign four_wire_command_mode = st_reg.four_wire;
	assign program_suspended_flag = st_reg.prog_sus;
	assign erase_suspended_flag   = st_reg.erase_sus;
	always_comb
	begin
		suspend_field                   = '0;
		suspend_field[program_susp_bit] = st_reg.prog_sus;
		suspend_field[erase_susp_bit]   = st_reg.erase_sus;
	end

	// Checks; timing bounds assume ce stays high
	localparam int entry_bound = ENTRY_CYCLES;

	a_read_in_suspend:
	assert property (@(posedge clk) disable iff (srst)
		commit && st_reg.mode == mode_active && (st_reg.prog_sus || st_reg.erase_sus)
		&& st_reg.opcode == normal_read_cmd |=> accepted.valid && !refused)
	else $error("read refused during suspend");

	a_program_susp_refuse:
	assert property (@(posedge clk) disable iff (srst)
		commit && st_reg.mode == mode_active && st_reg.prog_sus
		&& st_reg.opcode == write_latch_set_cmd |=> refused && !accepted.valid)
	else $error("write enable accepted during program suspend");

	a_suspend_other_drop:
	assert property (@(posedge clk) disable iff (srst)
		commit && st_reg.mode == mode_active && st_reg.erase_sus
		&& st_reg.opcode == power_down_enter_cmd |=> refused ##1 st_reg.mode == mode_active)
	else $error("power-down entered during suspend");

	a_reset_needs_arm:
	assert property (@(posedge clk) disable iff (srst)
		commit && st_reg.mode == mode_active && st_reg.opcode == soft_reset_cmd
		&& !st_reg.reset_armed |=> refused && !soft_reset)
	else $error("soft reset without arm");

	a_entry_on_commit:
	assert property (@(posedge clk) disable iff (srst)
		$changed(st_reg.mode) && st_reg.mode == mode_entering
		|-> $past(commit) && $past(st_reg.opcode) == power_down_enter_cmd)
	else $error("power-down entry without committed opcode");

	a_entry_within_delay:
	assert property (@(posedge clk) disable iff (srst)
		$rose(st_reg.mode == mode_entering) |-> ##[1:entry_bound] power_down_flag)
	else $error("power-down not reached in time");

	a_powered_down_filter:
	assert property (@(posedge clk) disable iff (srst)
		commit && power_down_flag && st_reg.opcode != power_down_release_cmd
		|=> refused && power_down_flag)
	else $error("command accepted while powered down");

	a_release_blocks_all:
	assert property (@(posedge clk) disable iff (srst)
		commit && release_busy |=> !accepted.valid)
	else $error("command accepted during release delay");

	a_wip_blocks_release:
	assert property (@(posedge clk) disable iff (srst)
		commit && power_down_flag && write_in_progress_flag |=> power_down_flag && refused)
	else $error("release honoured during write in progress");

	a_partial_no_commit:
	assert property (@(posedge clk) disable iff (srst)
		ce && ctl_rise[1] && st_reg.bit_cnt != 3'h0 |=> !accepted.valid && !refused)
	else $error("partial opcode committed");

	a_four_wire_entry:
	assert property (@(posedge clk) disable iff (srst)
		$rose(four_wire_command_mode) |-> $past(commit)
		&& $past(st_reg.opcode) == four_wire_mode_enter_cmd)
	else $error("four-wire mode without enter opcode");

endmodule : suspend_powerdown_cmd_gate

// ---- core/cmd_gate_pkg.sv ----
// Opcodes, timing constants, carrier structs and state types of the command gate.
// Assumes a 250 MHz core clock and a host that shifts opcodes most significant bit first.
package cmd_gate_pkg;

	// Core clock
	localparam int clk_period_ps = 4000;

	// Power-down timing, in nanoseconds
	localparam int power_down_entry_delay_ns   = 3000;
	localparam int power_down_release_delay_ns = 5000;

	// Entry is a longest time: round down. Release is a least time: round up.
	localparam int entry_raw     = (power_down_entry_delay_ns * 1000) / clk_period_ps;
	localparam int entry_cycles  = (entry_raw < 1) ? 1 : entry_raw;
	localparam int release_raw   = (power_down_release_delay_ns * 1000 + clk_period_ps - 1)
		/ clk_period_ps;
	localparam int release_cycles = (release_raw < 1) ? 1 : release_raw;
	localparam int delay_cnt_w   = 16;

	// Shift counter steps per link clock edge
	localparam logic [2:0] single_wire_step = 3'h1;
	localparam logic [2:0] four_wire_step   = 3'h4;

	// Function register suspend bit positions
	localparam int func_reg_w     = 8;
	localparam int program_susp_bit = 2;
	localparam int erase_susp_bit   = 3;

	// Opcodes
	localparam logic [7:0] normal_read_cmd             = 8'h03;
	localparam logic [7:0] fast_read_cmd               = 8'h0B;
	localparam logic [7:0] dual_io_fast_read_cmd       = 8'hBB;
	localparam logic [7:0] dual_out_fast_read_cmd      = 8'h3B;
	localparam logic [7:0] quad_io_fast_read_cmd       = 8'hEB;
	localparam logic [7:0] quad_out_fast_read_cmd      = 8'h6B;
	localparam logic [7:0] double_rate_read_cmd        = 8'h0D;
	localparam logic [7:0] dual_double_rate_read_cmd   = 8'hBD;
	localparam logic [7:0] quad_double_rate_read_cmd   = 8'hED;
	localparam logic [7:0] serial_page_program_cmd     = 8'h02;
	localparam logic [7:0] quad_page_program_cmd       = 8'h32;
	localparam logic [7:0] quad_page_program_alt_cmd   = 8'h38;
	localparam logic [7:0] write_latch_set_cmd         = 8'h06;
	localparam logic [7:0] status_read_cmd             = 8'h05;
	localparam logic [7:0] function_reg_read_cmd       = 8'h48;
	localparam logic [7:0] error_flags_clear_cmd       = 8'h82;
	localparam logic [7:0] resume_cmd                  = 8'h7A;
	localparam logic [7:0] resume_alt_cmd              = 8'h30;
	localparam logic [7:0] suspend_cmd                 = 8'h75;
	localparam logic [7:0] suspend_alt_cmd             = 8'hB0;
	localparam logic [7:0] legacy_id_read_cmd          = 8'hAB;
	localparam logic [7:0] power_down_release_cmd      = legacy_id_read_cmd;
	localparam logic [7:0] volatile_read_param_set_cmd = 8'hC0;
	localparam logic [7:0] volatile_read_param_alt_cmd = 8'h63;
	localparam logic [7:0] volatile_ext_param_set_cmd  = 8'h83;
	localparam logic [7:0] read_param_read_cmd         = 8'h61;
	localparam logic [7:0] ext_param_read_cmd          = 8'h81;
	localparam logic [7:0] standard_id_read_cmd        = 8'h9F;
	localparam logic [7:0] maker_device_id_read_cmd    = 8'h90;
	localparam logic [7:0] quad_standard_id_read_cmd   = 8'hAF;
	localparam logic [7:0] unique_number_read_cmd      = 8'h4B;
	localparam logic [7:0] param_table_read_cmd        = 8'h5A;
	localparam logic [7:0] no_operation_cmd            = 8'h00;
	localparam logic [7:0] reset_arm_cmd               = 8'h66;
	localparam logic [7:0] soft_reset_cmd              = 8'h99;
	localparam logic [7:0] info_row_read_cmd           = 8'h68;
	localparam logic [7:0] sector_unlock_cmd           = 8'h26;
	localparam logic [7:0] sector_lock_cmd             = 8'h24;
	localparam logic [7:0] boot_reg_read_cmd           = 8'h14;
	localparam logic [7:0] power_down_enter_cmd        = 8'hB9;
	localparam logic [7:0] four_wire_mode_enter_cmd    = 8'h35;
	localparam logic [7:0] four_wire_mode_exit_cmd     = 8'hF5;

	// Link pins as seen by the device
	typedef struct packed {
		logic       chip_en_n;
		logic       sclk;
		logic [3:0] sio;
	} link_pins_t;

	// Committed command handed to the rest of the device
	typedef struct packed {
		logic       valid;
		logic [7:0] opcode;
	} cmd_out_t;

	typedef enum logic [1:0] {
		mode_active,
		mode_entering,
		mode_powered_down,
		mode_releasing
	} gate_mode_t;

endpackage : cmd_gate_pkg

// ---- core/edge_sync.sv ----
// Two-flop synchroniser with edge detection for a group of link pins.
// Assumes inputs are asynchronous to clk and change slower than two core cycles.
`timescale 1ns/1ps
module edge_sync
	import cmd_gate_pkg::*;
#(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} sync_t;

	sync_t st_reg;
	sync_t st_next;

	// Stage one feeds only stage two
	always_comb
	begin
		st_next      = st_reg;
		st_next.meta = async_in;
		st_next.sync = st_reg.meta;
		st_next.prev = st_reg.sync;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_reg <= '{meta: RST_VAL, sync: RST_VAL, prev: RST_VAL}; // Idle level: no false edge
		else if (ce)
			st_reg <= st_next;
	end

	// Edges seen between stage two and three
	assign level = st_reg.sync;
	assign rise  = st_reg.sync & ~st_reg.prev;
	assign fall  = ~st_reg.sync & st_reg.prev;

endmodule : edge_sync

// ---- tb/host_link_model.sv ----
// Host side of the serial link: frames opcodes on chip enable, link clock and data.
// Assumes calls start just after a core clock edge; link clock parks low between frames.
`timescale 1ns/1ps
module host_link_model
	import cmd_gate_pkg::*;
#(
	parameter int HALF_NS = 24
)(
	output link_pins_t pins
);
	// Idle: deselected, link clock still
	initial
	begin
		pins = '{chip_en_n: 1'b1, sclk: 1'b0, sio: 4'h0};
	end

	// One frame; gap first so the answer right after the rise is not missed
	task automatic send_frame(input logic [7:0] op, input int nbits, input logic quad);
		int i;
		#(2 * HALF_NS);
		pins.chip_en_n = 1'b0;
		#HALF_NS;
		for (i = 0; i < nbits; i = i + (quad ? 4 : 1))
		begin
			if (quad)
				pins.sio = op[7 - i -: 4];
			else
				pins.sio[0] = op[7 - i];
			#HALF_NS;
			pins.sclk = 1'b1;
			#HALF_NS;
			pins.sclk = 1'b0;
		end
		// Released data shows the inverse, so a stale bit never looks valid
		pins.sio = ~pins.sio;
		#HALF_NS;
		pins.chip_en_n = 1'b1;
	endtask : send_frame
endmodule : host_link_model

// ---- tb/suspend_powerdown_cmd_gate_tb.sv ----
// Self-checking bench of the command gate: suspend filtering and power-down.
// Assumes the host model in host_link_model and short entry and release counts.
`timescale 1ns/1ps
module suspend_powerdown_cmd_gate_tb
	import cmd_gate_pkg::*;
;
	localparam int ENTRY = 4;
	localparam int REL   = 6;
	localparam logic [7:0] tbl [39] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D,
		8'hBD, 8'hED, 8'h05, 8'h48, 8'h82, 8'hC0, 8'h63, 8'h83, 8'h61, 8'h81, 8'h9F, 8'hAF,
		8'h4B, 8'h5A, 8'h68, 8'h14, 8'hAB, 8'h90, 8'h00, 8'h66, 8'h02, 8'h32, 8'h38, 8'h06,
		8'h26, 8'h24, 8'h65, 8'h85, 8'h01, 8'hB9, 8'h35, 8'hC7};

	logic       clk;
	logic       srst;
	logic       ce;
	logic       wr_busy;
	logic       pa;
	logic       ea;
	link_pins_t pins;
	cmd_out_t   accepted;
	logic       refused;
	logic       soft_reset;
	logic       power_down_flag;
	logic       release_busy;
	logic       four_wire_command_mode;
	logic       prog_sus;
	logic       erase_sus;
	logic [7:0] suspend_field;
	logic       got_acc;
	logic       got_ref;
	logic       got_sr;
	logic [7:0] got_op;
	logic [7:0] op;
	int         err_count;
	int         n_checks;
	int         seed;
	int         cycles;
	int         k;
	int         q;

	host_link_model host_u (.pins(pins));

	suspend_powerdown_cmd_gate #(.ENTRY_CYCLES(ENTRY), .RELEASE_CYCLES(REL)) dut_u (
		.clk(clk), .srst(srst), .ce(ce), .pins(pins), .write_in_progress_flag(wr_busy),
		.program_active(pa), .erase_active(ea), .accepted(accepted), .refused(refused),
		.soft_reset(soft_reset), .power_down_flag(power_down_flag),
		.release_busy(release_busy), .four_wire_command_mode(four_wire_command_mode),
		.program_suspended_flag(prog_sus), .erase_suspended_flag(erase_sus),
		.suspend_field(suspend_field));

	// 250 MHz core clock
	initial
	begin
		clk = 1'b0;
	end
	always #2 clk = ~clk;

	// Hang guard, well above the roughly 15k cycles the run needs
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 60000)
		begin
			err_count = err_count + 1;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic check_bit(input logic got, input logic exp);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("BAD bit at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check_bit

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("BAD byte at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check_byte

	// Opcodes honoured in each suspend state; normal state takes all
	function automatic logic exp_ok(input logic [7:0] o, input logic ps, input logic es);
		if (!ps && !es)
			return 1'b1;
		case (o)
			8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED, 8'h05, 8'h48,
			8'h82, 8'hC0, 8'h63, 8'h83, 8'h61, 8'h81, 8'h9F, 8'hAF, 8'h4B, 8'h5A, 8'h68,
			8'h14, 8'hAB, 8'h90, 8'h00, 8'h66, 8'h7A, 8'h30: return 1'b1;
			8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hB0, 8'h26, 8'h24: return !ps;
			default: return 1'b0;
		endcase
	endfunction : exp_ok

	// Catch the one-cycle answer pulse within a bounded window
	task automatic get_resp();
		int i;
		got_acc = 1'b0;
		got_ref = 1'b0;
		got_sr  = 1'b0;
		for (i = 0; i < 12; i++)
		begin
			@(posedge clk);
			#1;
			if (accepted.valid === 1'b1 || refused === 1'b1)
			begin
				got_acc = accepted.valid;
				got_ref = refused;
				got_op  = accepted.opcode;
				got_sr  = soft_reset;
				break;
			end
		end
	endtask : get_resp

	task automatic do_cmd(input logic [7:0] o, input int nb, input logic qd,
		input logic pulse, input logic acc);
		host_u.send_frame(o, nb, qd);
		get_resp();
		check_bit(got_acc, pulse & acc);
		check_bit(got_ref, pulse & ~acc);
		if (pulse & acc)
			check_byte(got_op, o);
	endtask : do_cmd

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
		end
	endtask : tick

	// Run every table opcode in the current suspend state
	task automatic sweep(input logic ps, input logic es);
		int i;
		for (i = 0; i < 39; i++)
			do_cmd(tbl[i], 8, 1'b0, 1'b1, exp_ok(tbl[i], ps, es));
	endtask : sweep

	// Main sequence
	initial
	begin
		seed = 44;
		err_count = 0;
		n_checks = 0;
		cycles = 0;
		srst = 1'b1;
		ce = 1'b1;
		wr_busy = 1'b0;
		pa = 1'b0;
		ea = 1'b0;
		tick(4);
		srst = 1'b0;
		tick(4);
		check_bit(power_down_flag, 1'b0);
		check_byte(suspend_field, 8'h00);
		// Random traffic in normal state; state-changing opcodes swapped for a read
		for (k = 0; k < 20; k++)
		begin
			op = 8'($random(seed));
			// Arm opcode swapped too, so the lone soft reset below stays unarmed
			if (op inside {8'hB9, 8'hAB, 8'h35, 8'hF5, 8'h75, 8'hB0, 8'h7A, 8'h30, 8'h99, 8'h66})
				op = 8'h03;
			do_cmd(op, 8, 1'b0, 1'b1, 1'b1);
		end
		// Partial opcode commits nothing
		do_cmd(8'hB9, 5, 1'b0, 1'b0, 1'b0);
		tick(ENTRY + 4);
		check_bit(power_down_flag, 1'b0);
		// Soft reset only right after arm
		do_cmd(8'h99, 8, 1'b0, 1'b1, 1'b0);
		check_bit(got_sr, 1'b0);
		do_cmd(8'h66, 8, 1'b0, 1'b1, 1'b1);
		do_cmd(8'h99, 8, 1'b0, 1'b1, 1'b1);
		check_bit(got_sr, 1'b1);
		// Program suspend
		pa = 1'b1;
		do_cmd(8'h75, 8, 1'b0, 1'b1, 1'b1);
		check_bit(prog_sus, 1'b1);
		check_byte(suspend_field, 8'h04);
		sweep(1'b1, 1'b0);
		do_cmd(8'hB0, 8, 1'b0, 1'b1, 1'b0);
		do_cmd(8'h7A, 8, 1'b0, 1'b1, 1'b1);
		check_byte(suspend_field, 8'h00);
		pa = 1'b0;
		// Erase suspend
		ea = 1'b1;
		do_cmd(8'hB0, 8, 1'b0, 1'b1, 1'b1);
		check_bit(erase_sus, 1'b1);
		check_byte(suspend_field, 8'h08);
		sweep(1'b0, 1'b1);
		do_cmd(8'h30, 8, 1'b0, 1'b1, 1'b1);
		check_bit(erase_sus, 1'b0);
		ea = 1'b0;
		// Power-down entry and release, single-wire then four-wire
		for (q = 0; q < 2; q++)
		begin
			if (q == 1)
			begin
				do_cmd(8'h35, 8, 1'b0, 1'b1, 1'b1);
				check_bit(four_wire_command_mode, 1'b1);
			end
			do_cmd(8'hB9, 8, q[0], 1'b1, 1'b1);
			check_bit(power_down_flag, 1'b0);
			for (k = 0; k < ENTRY + 2 && power_down_flag !== 1'b1; k++)
				tick(1);
			check_bit(power_down_flag, 1'b1);
			// Frozen core misses a whole release frame and stays powered down
			ce = 1'b0;
			do_cmd(8'hAB, 8, q[0], 1'b0, 1'b0);
			check_bit(power_down_flag, 1'b1);
			ce = 1'b1;
			do_cmd(8'h05, 8, q[0], 1'b1, 1'b0);
			do_cmd(8'h06, 8, q[0], 1'b1, 1'b0);
			wr_busy = 1'b1;
			do_cmd(8'hAB, 8, q[0], 1'b1, 1'b0);
			check_bit(power_down_flag, 1'b1);
			wr_busy = 1'b0;
			do_cmd(8'hAB, 8, q[0], 1'b1, 1'b1);
			check_bit(release_busy, 1'b1);
			tick(REL - 2);
			check_bit(release_busy, 1'b1);
			// Host keeps chip enable high until the release delay is over
			for (k = 0; k < 4 && release_busy !== 1'b0; k++)
				tick(1);
			check_bit(release_busy, 1'b0);
			check_bit(power_down_flag, 1'b0);
			if (q == 1)
			begin
				do_cmd(8'hF5, 8, 1'b1, 1'b1, 1'b1);
				check_bit(four_wire_command_mode, 1'b0);
			end
		end
		print_verdict();
	end
endmodule : suspend_powerdown_cmd_gate_tb
